// ### logic/ccg_params.svh
// Register map, field positions, reset values and decode constants of the CPU clock generator
`ifndef CCG_PARAMS_SVH
`define CCG_PARAMS_SVH

// =====================================================
// Register offsets (byte addresses)
`define CCG_ADDR_RCFG 12'h000
`define CCG_ADDR_CTRL 12'h004
`define CCG_ADDR_STAT 12'h008

// =====================================================
// Fields and reset values
`define CCG_SEL_HI 7
`define CCG_SEL_LO 5
`define CCG_RCFG_RST 8'hff
`define CCG_CTRL_RUN_BIT 0
`define CCG_PER_RST 16'h0008

// =====================================================
// Clock generation select codes
`define CCG_SEL_X4 3'h7
`define CCG_SEL_X3 3'h6
`define CCG_SEL_X2 3'h5
`define CCG_SEL_X5 3'h4
`define CCG_SEL_DIRECT 3'h3
`define CCG_SEL_X1P5 3'h2
`define CCG_SEL_PRESC 3'h1
`define CCG_SEL_X2P5 3'h0

`endif

// ### logic/ccg_pkg.sv
// Types shared by the CPU clock generator
package ccg_pkg;

  typedef enum logic [1:0] {
    CCG_MODE_PRESC,
    CCG_MODE_DIRECT,
    CCG_MODE_PLL
  } ccg_mode_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ccg_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ccg_apb_rsp_s;

  typedef struct packed {
    logic [7:0] rcfg;
    logic run;
    logic cpu_clk;
    logic cpu_d;
    logic phase_p;
    logic osc_d;
    logic [15:0] per_cnt;
    logic [15:0] per_est;
    logic [16:0] acc;
    logic [1:0] trans;
    logic [31:0] prdata;
  } ccg_state_s;

endpackage : ccg_pkg

// ### logic/ccg_sync.sv
// Two-stage synchroniser for pin inputs
module ccg_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end

  assign q = s2_ff;

endmodule : ccg_sync

// ### logic/ccg_clock_gen.sv
// CPU clock generator: prescaler, direct drive or multiplying loop, mode strapped at long reset
// =====================================================
`include "ccg_params.svh"

module ccg_clock_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic oscillator_input,
  input wire logic [7:0] port0_upper_half,
  input wire logic long_hw_reset_n,
  input wire ccg_pkg::ccg_apb_req_s apb_req,
  output ccg_pkg::ccg_apb_rsp_s apb_rsp,
  output logic cpu_clk,
  output logic half_clock_phase,
  output logic pll_enable,
  output logic [2:0] clock_gen_select
);
  import ccg_pkg::*;

  // Doubled factor, so 1.5 and 2.5 stay integral
  function automatic logic [3:0] mult2_of(input logic [2:0] sel);
    case (sel)
      `CCG_SEL_X4: mult2_of = 4'h8;
      `CCG_SEL_X3: mult2_of = 4'h6;
      `CCG_SEL_X2: mult2_of = 4'h4;
      `CCG_SEL_X5: mult2_of = 4'ha;
      `CCG_SEL_DIRECT: mult2_of = 4'h2;
      `CCG_SEL_X1P5: mult2_of = 4'h3;
      `CCG_SEL_PRESC: mult2_of = 4'h1;
      default: mult2_of = 4'h5;
    endcase
  endfunction : mult2_of

  function automatic ccg_mode_e mode_of(input logic [2:0] sel);
    case (sel)
      `CCG_SEL_PRESC: mode_of = CCG_MODE_PRESC;
      `CCG_SEL_DIRECT: mode_of = CCG_MODE_DIRECT;
      default: mode_of = CCG_MODE_PLL;
    endcase
  endfunction : mode_of

  // =====================================================
  // Pin synchronisation
  logic [9:0] pins_q;
  logic osc_q;
  logic long_rst_q;
  logic [7:0] strap_q;

  ccg_sync #(.W(10)) ccg_sync_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({oscillator_input, ~long_hw_reset_n, port0_upper_half}),
    .q(pins_q)
  );

  assign osc_q = pins_q[9];
  assign long_rst_q = pins_q[8];
  assign strap_q = pins_q[7:0];

  // =====================================================
  // State
  ccg_state_s s;
  ccg_state_s nxt_s;
  logic [2:0] sel;
  ccg_mode_e mode;
  logic [3:0] mult2;
  logic osc_rise;
  logic osc_edge;
  logic [1:0] sync_len;
  logic resync;
  logic [16:0] acc_sum;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  assign sel = s.rcfg[`CCG_SEL_HI:`CCG_SEL_LO];
  assign mode = mode_of(sel);
  assign mult2 = mult2_of(sel);
  assign osc_rise = osc_q & ~s.osc_d;
  assign osc_edge = osc_q ^ s.osc_d;
  // Both clocks line up after one input period, or two for the half-integer factors
  assign sync_len = mult2[0] ? 2'h3 : 2'h1;
  assign resync = (mode == CCG_MODE_PLL) && osc_edge && (s.trans == sync_len);
  assign acc_sum = 17'(s.acc + 17'(mult2));

  assign addr_ok = (apb_req.paddr == `CCG_ADDR_RCFG) || (apb_req.paddr == `CCG_ADDR_CTRL) ||
                   (apb_req.paddr == `CCG_ADDR_STAT);
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && addr_ok;
  assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

  always_comb begin
    nxt_s = s;
    nxt_s.osc_d = osc_q;
    nxt_s.cpu_d = s.cpu_clk;
    nxt_s.phase_p = s.cpu_clk ^ s.cpu_d;
    // Capture repeats every cycle of the long reset so the last level wins
    // Only rst_n, which loads 8'hff, also writes the strap byte, so the mode holds until the next long reset or rst_n
    if (long_rst_q) begin
      nxt_s.rcfg = strap_q;
    end
    // Oscillator period measure, averaged so each new period moves the loop only half way
    if (osc_rise) begin
      nxt_s.per_cnt = 16'h0001;
      nxt_s.per_est = 16'(({1'b0, s.per_est} + {1'b0, s.per_cnt}) >> 1);
    end else if (s.per_cnt != 16'hffff) begin
      nxt_s.per_cnt = 16'(s.per_cnt + 16'h0001);
    end
    if (!s.run) begin
      nxt_s.cpu_clk = 1'b0;
      nxt_s.acc = '0;
      nxt_s.trans = '0;
    end else begin
      case (mode)
        CCG_MODE_PRESC: begin
          if (osc_rise) begin
            nxt_s.cpu_clk = ~s.cpu_clk;
          end
        end
        CCG_MODE_DIRECT: begin
          nxt_s.cpu_clk = osc_q;
        end
        CCG_MODE_PLL: begin
          // Numerically controlled loop: 2F toggles per measured input period
          if (acc_sum >= {1'b0, s.per_est}) begin
            nxt_s.acc = 17'(acc_sum - {1'b0, s.per_est});
            nxt_s.cpu_clk = ~s.cpu_clk;
          end else begin
            nxt_s.acc = acc_sum;
          end
          if (resync) begin
            nxt_s.acc = '0;
            nxt_s.trans = '0;
            nxt_s.cpu_clk = 1'b0;
          end else if (osc_edge) begin
            nxt_s.trans = 2'(s.trans + 2'h1);
          end
        end
        default: begin
          nxt_s.cpu_clk = 1'b0;
        end
      endcase
    end
    if (wr_en && apb_req.paddr == `CCG_ADDR_CTRL) begin
      nxt_s.run = apb_req.pwdata[`CCG_CTRL_RUN_BIT];
    end
    if (rd_en) begin
      case (apb_req.paddr)
        `CCG_ADDR_RCFG: nxt_s.prdata = {24'h000000, s.rcfg};
        `CCG_ADDR_CTRL: nxt_s.prdata = {31'h0, s.run};
        `CCG_ADDR_STAT: nxt_s.prdata = {12'h000, (mode == CCG_MODE_PLL), sel, s.per_est};
        default: nxt_s.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.rcfg <= `CCG_RCFG_RST;
      s.run <= 1'b1;
      s.per_est <= `CCG_PER_RST;
    end else begin
      s <= nxt_s;
    end
  end

  // =====================================================
  // Outputs
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok;
  assign apb_rsp.prdata = s.prdata;
  assign cpu_clk = s.cpu_clk;
  assign half_clock_phase = s.phase_p;
  assign pll_enable = (mode == CCG_MODE_PLL);
  assign clock_gen_select = sel;

  // =====================================================
  // Checks
  capture_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    long_rst_q |=> s.rcfg == $past(strap_q)) else $error("select not captured from pins");

  mode_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !long_rst_q |=> $stable(s.rcfg)) else $error("mode changed outside long reset");

  factor_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel == 3'h7 |-> mult2 == 4'h8) and (sel == 3'h4 |-> mult2 == 4'ha) and
    (sel == 3'h0 |-> mult2 == 4'h5)) else $error("factor decode wrong");

  loop_enable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pll_enable == (sel != 3'h3 && sel != 3'h1)) else $error("loop enable wrong for mode");

  presc_toggle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel == 3'h1 && s.run && !long_rst_q && osc_rise) |=> cpu_clk != $past(cpu_clk))
    else $error("prescaler missed oscillator rise");

  presc_steady_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel == 3'h1 && s.run && !long_rst_q && !osc_rise) |=> $stable(cpu_clk))
    else $error("prescaler toggled without oscillator rise");

  direct_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel == 3'h3 && s.run && !long_rst_q) |=> cpu_clk == $past(osc_q))
    else $error("direct drive does not follow oscillator");

  phase_mark_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cpu_clk != $past(cpu_clk)) |=> half_clock_phase) else $error("phase marker missing");

  loop_resync_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (resync && s.run && !long_rst_q) |=> (s.acc == 17'h00000 && !cpu_clk))
    else $error("loop not resynchronised");

  unmapped_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (apb_req.psel && apb_req.penable && !addr_ok) |-> apb_rsp.pslverr)
    else $error("unmapped access without error");

endmodule : ccg_clock_gen

// ### tb/ccg_osc_model.sv
// Oscillator source feeding the clock generator
module ccg_osc_model (
  input wire logic [15:0] hi_ns,
  input wire logic [15:0] lo_ns,
  output logic oscillator_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // Off-grid start keeps pin edges clear of sys_clk edges
  initial begin
    oscillator_input = 1'b0;
    #7;
    forever begin
      oscillator_input = 1'b1;
      #(hi_ns);
      oscillator_input = 1'b0;
      #(lo_ns);
    end
  end
endmodule : ccg_osc_model

// ### tb/ccg_clock_gen_tb_top.sv
// Self-checking bench for the CPU clock generator
`include "ccg_params.svh"
module ccg_clock_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccg_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic long_n = 1'b1;
  logic [7:0] pins = 8'hff;
  logic [15:0] hi_ns = 16'h0028;
  logic [15:0] lo_ns = 16'h0078;
  logic osc, cpu_clk, hcp, pll_en;
  logic [2:0] sel;
  logic [31:0] rd;
  logic er;
  ccg_apb_req_s req = '0;
  ccg_apb_rsp_s rsp;
  int err_total = 0;
  int check_count = 0;
  int h, l, tg, hp;
  logic [2:0] codes [6] = '{3'h5, 3'h7, 3'h6, 3'h4, 3'h2, 3'h0};
  int rises [6] = '{20, 40, 30, 50, 15, 25};
  always #10 sys_clk = ~sys_clk;
  ccg_osc_model ccg_osc_model_inst (.hi_ns(hi_ns), .lo_ns(lo_ns), .oscillator_input(osc));
  ccg_clock_gen ccg_clock_gen_inst (.sys_clk(sys_clk), .rst_n(rst_n), .oscillator_input(osc),
    .port0_upper_half(pins), .long_hw_reset_n(long_n), .apb_req(req), .apb_rsp(rsp),
    .cpu_clk(cpu_clk), .half_clock_phase(hcp), .pll_enable(pll_en), .clock_gen_select(sel));
  // ==========================================
  // Shared tasks
  task chk_val(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk_val
  task chk_rng(string nm, int lo, int hi, int g);
    check_count++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task apb(logic wr, logic [11:0] a, logic [31:0] wd);
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    @(posedge sys_clk);
    // Only the watchdog ends a wait for pready
    while (rsp.pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask : apb
  task strap(logic [2:0] c);
    @(posedge sys_clk);
    pins <= {c, 5'h0a};
    long_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    long_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : strap
  // Counts sys_clk cycles while cpu_clk stays at v; sampled mid-cycle
  task cnt_lvl(logic v, output int c);
    c = 0;
    @(negedge sys_clk);
    while (cpu_clk === v && c < 2000) begin
      c++;
      @(negedge sys_clk);
    end
  endtask : cnt_lvl
  // ==========================================
  // Scenarios
  task t_regs();
    apb(1'b0, `CCG_ADDR_RCFG, 32'h0);
    chk_val("rcfg", {24'h0, `CCG_RCFG_RST}, rd);
    apb(1'b0, `CCG_ADDR_CTRL, 32'h0);
    chk_val("ctrl_rst", 32'h1, rd);
    apb(1'b1, `CCG_ADDR_RCFG, 32'h0);
    apb(1'b0, `CCG_ADDR_RCFG, 32'h0);
    chk_val("rcfg_ro", {24'h0, `CCG_RCFG_RST}, rd);
    apb(1'b0, `CCG_ADDR_STAT, 32'h0);
    chk_val("stat_sel", 32'hf, {28'h0, rd[19:16]});
    apb(1'b0, 12'h00c, 32'h0);
    chk_val("slverr", 32'h1, {31'h0, er});
    chk_val("unmapped_rd", 32'h0, rd);
  endtask : t_regs
  task t_strap();
    for (int i = 0; i < 8; i++) begin
      strap(i[2:0]);
      chk_val("sel", i, {29'h0, sel});
      chk_val("pll_en", (i != 3 && i != 1), {31'h0, pll_en});
      apb(1'b0, `CCG_ADDR_RCFG, 32'h0);
      chk_val("rcfg_sel", i, {29'h0, rd[7:5]});
    end
    pins <= 8'h00;
    repeat (8) @(posedge sys_clk);
    chk_val("sel_hold", 32'h7, {29'h0, sel});
  endtask : t_strap
  // Uneven input duty: prescaler must even it out, direct drive must keep it
  task t_phase(logic [2:0] c, int eh, int el);
    strap(c);
    repeat (40) @(posedge sys_clk);
    // Run out the current levels so that counting starts just after the first high cycle
    cnt_lvl(1'b1, h);
    cnt_lvl(1'b0, h);
    // The first cycle of each level is already seen on entry, hence the +1
    cnt_lvl(1'b1, h);
    cnt_lvl(1'b0, l);
    chk_rng("phase_hi", eh, eh, h + 1);
    chk_rng("phase_lo", el, el, l + 1);
  endtask : t_phase
  task t_loop();
    hi_ns <= 16'h0280;
    lo_ns <= 16'h0280;
    for (int i = 0; i < 6; i++) begin
      strap(codes[i]);
      repeat (1280) @(posedge sys_clk);
      tg = 0;
      hp = 0;
      h = cpu_clk;
      repeat (640) begin
        @(negedge sys_clk);
        if (cpu_clk !== h[0]) tg++;
        if (hcp === 1'b1) hp++;
        h = cpu_clk;
      end
      chk_rng("loop_edges", 2 * rises[i] - 3, 2 * rises[i] + 3, tg);
      chk_rng("phase_units", tg - 1, tg + 1, hp);
      apb(1'b0, `CCG_ADDR_STAT, 32'h0);
      chk_val("stat_mode", {29'h0, codes[i]}, {29'h0, rd[18:16]});
      // Input period is 1280 ns, 64 sys_clk cycles; the averaging rounds down
      chk_rng("per_est", 62, 64, int'(rd[15:0]));
    end
  endtask : t_loop
  task t_run();
    apb(1'b1, `CCG_ADDR_CTRL, 32'h0);
    apb(1'b0, `CCG_ADDR_CTRL, 32'h0);
    chk_val("run_bit", 32'h0, rd);
    // The stop lands one cycle after the write; let cpu_clk settle low first
    repeat (2) @(posedge sys_clk);
    cnt_lvl(1'b0, h);
    chk_rng("run_off", 2000, 2000, h);
    apb(1'b1, `CCG_ADDR_CTRL, 32'h1);
    cnt_lvl(1'b0, h);
    chk_rng("run_on", 0, 100, h);
  endtask : t_run
  task print_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #1500000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_strap();
    t_phase(`CCG_SEL_PRESC, 8, 8);
    t_phase(`CCG_SEL_DIRECT, 2, 6);
    t_loop();
    t_run();
    print_verdict();
  end
endmodule : ccg_clock_gen_tb_top
